// ---- src/ebi_master.sv ----
// External memory bus master: address, data, byte strobes, output enable, direction, start.
// Assumes requests come from on-chip logic on clk; acknowledges and data arrive from pins.
`timescale 1ns/10ps

module ebi_master (
  input  wire logic        clk,                  // System clock, 100 MHz
  input  wire logic        rstn,                 // Asynchronous reset, active low
  input  wire logic        req_valid,            // Access request
  output logic             req_ready,            // Request taken when high with req_valid
  input  wire logic [31:0] req_addr,             // Internal transfer address
  input  wire logic        req_write,            // 1 write, 0 read
  input  wire logic [1:0]  req_size,             // Byte, word or longword
  input  wire logic [1:0]  req_target,           // External, SDRAM, chip peripheral, chip memory
  input  wire logic [31:0] req_wdata,            // Write data, already in lane position
  output logic             rsp_valid,            // One-cycle completion pulse
  output logic             rsp_error,            // Access error, with rsp_valid
  output logic [31:0]      rsp_rdata,            // Read data, with rsp_valid
  input  wire logic        cfg_bus16,            // External bus is 16 bits wide
  input  wire logic        cfg_cs_alt,           // Upper address pins act as selects
  input  wire logic [2:0]  cs_alt_n,             // Select levels for the upper pins
  input  wire logic [23:0] cfg_addr_gpio,        // Address pins used as general I/O
  input  wire logic [23:0] gpio_addr_out,        // General I/O out levels, address pins
  input  wire logic [23:0] gpio_addr_en,         // General I/O drive enables, address pins
  output logic [23:0]      gpio_addr_in,         // General I/O in levels, address pins
  input  wire logic [15:0] gpio_data_out,        // General I/O out levels, low data pins
  input  wire logic [15:0] gpio_data_en,         // General I/O drive enables, low data pins
  output logic [15:0]      gpio_data_in,         // General I/O in levels, low data pins
  output logic [23:0]      addr_o,               // Address pin levels
  output logic [23:0]      addr_oe,              // Address pin drive enables
  input  wire logic [23:0] addr_i,               // Address pin levels seen
  output logic [31:0]      data_o,               // Data pin levels
  output logic [31:0]      data_oe,              // Data pin drive enables
  input  wire logic [31:0] data_i,               // Data pin levels seen
  output logic [3:0]       byte_lane_strobe_n,   // Lane strobes, column strobes for SDRAM
  output logic             read_enable_n,        // External read output enable, active low
  output logic             read_not_write,       // Direction: 1 read, 0 write
  output logic             transfer_begin_n,     // Transfer start, active low
  input  wire logic        transfer_ack_n,       // Transfer acknowledge, active low
  input  wire logic        transfer_error_ack_n  // Transfer error acknowledge, active low
);

  ebi_pkg::ebi_state_e state_q;
  logic [31:0]         addr_q;
  logic                write_q;
  logic [1:0]          target_q;
  logic [3:0]          mask_q;
  logic [31:0]         wdata_q;
  logic [33:0]         bus_sync;
  logic                ack_s_n;
  logic                err_s_n;
  logic                in_cycle;
  logic                sdram;
  logic [23:0]         addr_fn;

  // ==========================================================================
  // Lane mask: bit k is strobe k, strobe 0 the most significant lane
  function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] a, input logic bus16);
    logic [3:0] m;
    m = 4'h0;
    if (bus16)
    begin
      unique case (size)
        ebi_pkg::SZ_BYTE: m = a[0] ? 4'h2 : 4'h1;
        default:          m = 4'h3;
      endcase
    end
    else
    begin
      unique case (size)
        ebi_pkg::SZ_BYTE: m = 4'h1 << a;
        ebi_pkg::SZ_WORD: m = a[1] ? 4'hc : 4'h3;
        default:          m = 4'hf;
      endcase
    end
    return m;
  endfunction : lane_mask

  // ==========================================================================
  // Pin input synchronisers
  ebi_pin_sync #(
    .WIDTH     (34),
    .RESET_VAL (ebi_pkg::BUS_SYNC_RST)
  ) u_bus_sync (
    .clk    (clk),
    .rstn   (rstn),
    .pin_i  ({transfer_error_ack_n, transfer_ack_n, data_i}),
    .sync_o (bus_sync)
  );

  ebi_pin_sync #(
    .WIDTH     (24),
    .RESET_VAL (ebi_pkg::GPIO_SYNC_RST)
  ) u_gpio_sync (
    .clk    (clk),
    .rstn   (rstn),
    .pin_i  (addr_i),
    .sync_o (gpio_addr_in)
  );

  assign ack_s_n      = bus_sync[32];
  assign err_s_n      = bus_sync[33];
  assign gpio_data_in = bus_sync[15:0];

  // ==========================================================================
  // Sequencer
  assign req_ready = (state_q == ebi_pkg::ST_IDLE);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= ebi_pkg::ST_IDLE;
    else
    begin
      unique case (state_q)
        ebi_pkg::ST_IDLE:
        begin
          if (req_valid)
          begin
            unique case (req_target)
              ebi_pkg::TGT_CHIP_MEM: state_q <= ebi_pkg::ST_IDLE;
              ebi_pkg::TGT_CHIP_PER: state_q <= ebi_pkg::ST_INTERNAL;
              default:               state_q <= ebi_pkg::ST_START;
            endcase
          end
        end
        ebi_pkg::ST_START:    state_q <= ebi_pkg::ST_WAIT;
        ebi_pkg::ST_WAIT:
        begin
          if (!err_s_n || !ack_s_n)
            state_q <= ebi_pkg::ST_RECOVER;
        end
        ebi_pkg::ST_INTERNAL: state_q <= ebi_pkg::ST_IDLE;
        ebi_pkg::ST_RECOVER:
        begin
          if (ack_s_n && err_s_n)
            state_q <= ebi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Request capture
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_q   <= 32'h0000_0000;
      write_q  <= 1'b0;
      target_q <= ebi_pkg::TGT_EXT;
      mask_q   <= 4'h0;
      wdata_q  <= 32'h0000_0000;
    end
    else if (req_valid && req_ready)
    begin
      addr_q   <= req_addr;
      write_q  <= req_write;
      target_q <= req_target;
      mask_q   <= lane_mask(req_size, req_addr[1:0], cfg_bus16);
      wdata_q  <= req_wdata;
    end
  end

  // ==========================================================================
  // Completion
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      if (state_q == ebi_pkg::ST_IDLE && req_valid && req_target == ebi_pkg::TGT_CHIP_MEM)
        rsp_valid <= 1'b1;
      else if (state_q == ebi_pkg::ST_INTERNAL)
        rsp_valid <= 1'b1;
      else if (state_q == ebi_pkg::ST_WAIT && !err_s_n)
      begin
        rsp_valid <= 1'b1;
        rsp_error <= 1'b1;
      end
      else if (state_q == ebi_pkg::ST_WAIT && !ack_s_n)
      begin
        rsp_valid <= 1'b1;
        if (!write_q)
          rsp_rdata <= bus_sync[31:0];
      end
    end
  end

  // ==========================================================================
  // Bus control pins
  assign in_cycle = (state_q == ebi_pkg::ST_START) || (state_q == ebi_pkg::ST_WAIT);
  assign sdram    = (target_q == ebi_pkg::TGT_SDRAM);

  assign transfer_begin_n = !(state_q == ebi_pkg::ST_START);
  assign read_enable_n    = !(in_cycle && !write_q);
  assign read_not_write   = in_cycle ? !write_q : 1'b1;

  always_comb
  begin
    byte_lane_strobe_n = ebi_pkg::STROBE_IDLE;
    if (in_cycle && sdram)
      byte_lane_strobe_n = (state_q == ebi_pkg::ST_WAIT) ? mask_q : ebi_pkg::CAS_IDLE;
    else if (in_cycle || state_q == ebi_pkg::ST_INTERNAL)
      byte_lane_strobe_n = ~mask_q;
  end

  // ==========================================================================
  // Address pins
  always_comb
  begin
    addr_fn = addr_q[23:0];
    if (sdram && state_q == ebi_pkg::ST_START)
      addr_fn = {9'h000, addr_q[23:ebi_pkg::SDRAM_COLS]};
    else if (sdram)
      addr_fn = {15'h0000, addr_q[ebi_pkg::SDRAM_COLS-1:0]};
  end

  for (genvar i = 0; i < ebi_pkg::ADDR_PINS; i++)
  begin : g_addr
    if (i >= ebi_pkg::CS_ALT_LSB)
    begin : g_alt
      assign addr_o[i]  = cfg_cs_alt ? cs_alt_n[i-ebi_pkg::CS_ALT_LSB] :
                          cfg_addr_gpio[i] ? gpio_addr_out[i] : addr_fn[i];
      assign addr_oe[i] = cfg_cs_alt ? 1'b1 :
                          cfg_addr_gpio[i] ? gpio_addr_en[i] : in_cycle;
    end
    else
    begin : g_plain
      assign addr_o[i]  = cfg_addr_gpio[i] ? gpio_addr_out[i] : addr_fn[i];
      assign addr_oe[i] = cfg_addr_gpio[i] ? gpio_addr_en[i] : in_cycle;
    end
  end

  // ==========================================================================
  // Data pins
  assign data_o[31:16]  = wdata_q[31:16];
  assign data_oe[31:16] = {16{in_cycle && write_q}};
  assign data_o[15:0]   = cfg_bus16 ? gpio_data_out : wdata_q[15:0];
  assign data_oe[15:0]  = cfg_bus16 ? gpio_data_en : {16{in_cycle && write_q}};

endmodule : ebi_master

// ---- src/ebi_pin_sync.sv ----
// Three-stage synchroniser for pin inputs with an agreement filter.
// Assumes the input is asynchronous to clk; output follows once stages 2 and 3 agree.
`timescale 1ns/10ps

module ebi_pin_sync #(
  parameter int unsigned      WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,    // System clock
  input  wire logic             rstn,   // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] pin_i,  // Raw pin levels
  output logic      [WIDTH-1:0] sync_o  // Filtered levels
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ==========================================================================
  // Stage chain
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================================
  // Agreement filter: a bit moves only when stages 2 and 3 match
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sync_o <= RESET_VAL;
    else
      sync_o <= (s2_q & s3_q) | (sync_o & (s2_q ^ s3_q));
  end

endmodule : ebi_pin_sync

// ---- src/ebi_pkg.sv ----
// Constants shared by the external memory bus master and its pin synchroniser.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
package ebi_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_PINS    = 24;
  localparam int unsigned DATA_PINS    = 32;
  localparam int unsigned LANES        = 4;
  localparam int unsigned CS_ALT_LSB   = 21;
  localparam int unsigned CS_ALT_PINS  = 3;
  localparam int unsigned SDRAM_COLS   = 9;
  localparam int unsigned HALF_DATA    = 16;

  // ==========================================================================
  // Request targets
  localparam logic [1:0] TGT_EXT       = 2'h0;
  localparam logic [1:0] TGT_SDRAM     = 2'h1;
  localparam logic [1:0] TGT_CHIP_PER  = 2'h2;
  localparam logic [1:0] TGT_CHIP_MEM  = 2'h3;

  // ==========================================================================
  // Access sizes
  localparam logic [1:0] SZ_BYTE       = 2'h0;
  localparam logic [1:0] SZ_WORD       = 2'h1;
  localparam logic [1:0] SZ_LONG       = 2'h2;

  // ==========================================================================
  // Reset and idle values
  localparam logic [3:0]  STROBE_IDLE  = 4'hf;
  localparam logic [3:0]  CAS_IDLE     = 4'h0;
  localparam logic [33:0] BUS_SYNC_RST = 34'h3_0000_0000;
  localparam logic [23:0] GPIO_SYNC_RST = 24'h00_0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT,
    ST_INTERNAL,
    ST_RECOVER
  } ebi_state_e;

endpackage : ebi_pkg

// ---- test/ebi_ext_dev.sv ----
// External memory model for the bus master testbench.
// Assumes it sees the master's pins; answers after dly cycles with ack or error.
`timescale 1ns/10ps

module ebi_ext_dev (
  input  wire logic        clk,              // System clock
  input  wire logic        rstn,             // Reset, active low
  input  wire logic [23:0] addr_o,           // Address pins
  input  wire logic        read_enable_n,    // Read output enable
  input  wire logic        transfer_begin_n, // Transfer start
  input  wire logic [3:0]  dly,              // Wait cycles before answer
  input  wire logic        err_mode,         // Answer with error
  output logic      [31:0] dev_d,            // Data driven by the device
  output logic             ack_n,            // Acknowledge pin
  output logic             err_n             // Error acknowledge pin
);
  logic [23:0] adr_q;
  logic [4:0]  cnt_q;

  // Drives its word while reads are enabled, else the inverse of its word
  assign dev_d = !read_enable_n ? {adr_q[7:0], adr_q} : ~{adr_q[7:0], adr_q};

  // Answer held low for three cycles so the pin filter sees it
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      adr_q <= 24'h0;
      cnt_q <= 5'h0;
      ack_n <= 1'b1;
      err_n <= 1'b1;
    end
    else
    begin
      ack_n <= !(cnt_q inside {5'h2, 5'h3, 5'h4}) || err_mode;
      err_n <= !(cnt_q inside {5'h2, 5'h3, 5'h4}) || !err_mode;
      if (!transfer_begin_n)
      begin
        adr_q <= addr_o;
        cnt_q <= {1'b0, dly} + 5'h4;
      end
      else if (cnt_q != 5'h0)
        cnt_q <= cnt_q - 5'h1;
    end
endmodule : ebi_ext_dev

// ---- test/ebi_master_monitor.sv ----
// Port checker for the external bus master, bound into ebi_master.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/10ps

module ebi_master_chk (
  input wire logic        clk, rstn, req_valid, req_ready, cfg_bus16, cfg_cs_alt, rsp_valid, rsp_error,
  input wire logic        read_enable_n, read_not_write, transfer_begin_n, transfer_ack_n, transfer_error_ack_n,
  input wire logic [31:0] req_addr,
  input wire logic [1:0]  req_target, req_size,
  input wire logic [2:0]  cs_alt_n,
  input wire logic [23:0] addr_o, addr_oe,
  input wire logic [31:0] data_oe,
  input wire logic [3:0]  byte_lane_strobe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_take(logic [1:0] tg);
    req_valid && req_ready && req_target == tg;
  endsequence

  a_begin_one_cycle: assert property ($fell(transfer_begin_n) |=> transfer_begin_n)
    else $error("start pulse too long");
  a_begin_after_take: assert property (s_take(ebi_pkg::TGT_EXT) |=> !transfer_begin_n && !req_ready)
    else $error("no start after external request");
  a_oe_reads_only: assert property (!read_enable_n |-> read_not_write && data_oe[31:16] == 16'h0)
    else $error("output enable outside a read");
  a_idle_quiet: assert property (req_ready |-> read_enable_n && byte_lane_strobe_n == 4'hf)
    else $error("strobes active while idle");
  a_byte_lane_map: assert property (s_take(ebi_pkg::TGT_EXT) ##0 (req_size == ebi_pkg::SZ_BYTE && !cfg_bus16)
    |=> byte_lane_strobe_n == ~(4'h1 << $past(req_addr[1:0])))
    else $error("wrong byte strobe");
  a_sdram_row: assert property (s_take(ebi_pkg::TGT_SDRAM) ##0 !cfg_cs_alt
    |=> addr_o == {9'h0, $past(req_addr[23:9])} && byte_lane_strobe_n == 4'h0)
    else $error("bad row phase");
  a_chip_mem_quiet: assert property (s_take(ebi_pkg::TGT_CHIP_MEM)
    |=> rsp_valid && transfer_begin_n && byte_lane_strobe_n == 4'hf)
    else $error("chip memory access seen on pins");
  a_ack_ends_cycle: assert property ($fell(transfer_ack_n) && transfer_error_ack_n && !req_ready
    |-> ##[2:6] (rsp_valid && !rsp_error))
    else $error("acknowledge did not end cycle");
  a_error_ends_cycle: assert property ($fell(transfer_error_ack_n) && !req_ready
    |-> ##[2:6] (rsp_valid && rsp_error))
    else $error("error acknowledge not reported");
  a_select_pins: assert property (cfg_cs_alt |-> addr_oe[23:21] == 3'h7 && addr_o[23:21] == cs_alt_n)
    else $error("select pins wrong");
endmodule : ebi_master_chk

bind ebi_master ebi_master_chk u_ebi_master_chk (.clk, .rstn, .req_valid, .req_ready, .cfg_bus16, .cfg_cs_alt,
  .rsp_valid, .rsp_error, .read_enable_n, .read_not_write, .transfer_begin_n, .transfer_ack_n,
  .transfer_error_ack_n, .req_addr, .req_target, .req_size, .cs_alt_n, .addr_o, .addr_oe, .data_oe,
  .byte_lane_strobe_n);

// ---- test/tb.sv ----
// Self-checking testbench for the external bus master.
// Assumes ebi_ext_dev answers on the far side; the bench resolves the pins.
`timescale 1ns/10ps

module tb;
  logic        clk, rstn, req_valid, req_write, cfg_bus16, cfg_cs_alt, err_mode, rerr;
  logic [1:0]  req_size, req_target;
  logic [31:0] req_addr, req_wdata, rdat;
  logic [2:0]  cs_alt_n;
  logic [23:0] cfg_addr_gpio, gpio_addr_out, gpio_addr_en, pad_lvl;
  logic [15:0] gpio_data_out, gpio_data_en;
  logic [3:0]  dly;
  wire logic        req_ready, rsp_valid, rsp_error, read_enable_n, read_not_write, transfer_begin_n;
  wire logic        transfer_ack_n, transfer_error_ack_n;
  wire logic [31:0] rsp_rdata, data_o, data_oe, data_i, dev_d;
  wire logic [23:0] gpio_addr_in, addr_o, addr_oe, addr_i;
  wire logic [15:0] gpio_data_in;
  wire logic [3:0]  byte_lane_strobe_n;
  int          errors, cmp_count, lat;
  logic [31:0] cad[1:2], cdq[1:2], cdoe[1:2];
  logic [3:0]  cbs[1:2];
  logic        coe[1:2], crw[1:2], cbn[1:2];

  // ==========================================================================
  // Pins and instances
  assign data_i = (data_o & data_oe) | (dev_d & ~data_oe);
  assign addr_i = (addr_o & addr_oe) | (pad_lvl & ~addr_oe);

  ebi_master u_ebi_master (.clk, .rstn, .req_valid, .req_ready, .req_addr, .req_write, .req_size, .req_target,
    .req_wdata, .rsp_valid, .rsp_error, .rsp_rdata, .cfg_bus16, .cfg_cs_alt, .cs_alt_n, .cfg_addr_gpio,
    .gpio_addr_out, .gpio_addr_en, .gpio_addr_in, .gpio_data_out, .gpio_data_en, .gpio_data_in, .addr_o,
    .addr_oe, .addr_i, .data_o, .data_oe, .data_i, .byte_lane_strobe_n, .read_enable_n, .read_not_write,
    .transfer_begin_n, .transfer_ack_n, .transfer_error_ack_n);

  ebi_ext_dev u_ebi_ext_dev (.clk, .rstn, .addr_o, .read_enable_n, .transfer_begin_n, .dly, .err_mode,
    .dev_d, .ack_n(transfer_ack_n), .err_n(transfer_error_ack_n));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] dw(input logic [23:0] a);
    return {a[7:0], a};
  endfunction : dw

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One request; records the pins of the first two cycles and the answer
  task automatic acc(input logic [1:0] tg, input logic wr, input logic [1:0] sz, input logic [31:0] ad,
                     input logic [31:0] wd);
    int n;
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid  <= 1'b1;
    req_target <= tg;
    req_write  <= wr;
    req_size   <= sz;
    req_addr   <= ad;
    req_wdata  <= wd;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      if (n > 0)
        @(posedge clk);
      #1;
      n++;
      if (n < 3)
      begin
        cbs[n] = byte_lane_strobe_n;
        cad[n] = {8'h0, addr_o};
        cdq[n] = data_o;
        cdoe[n] = data_oe;
        coe[n] = read_enable_n;
        crw[n] = read_not_write;
        cbn[n] = transfer_begin_n;
      end
    end
    while (rsp_valid !== 1'b1 && n < 60);
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    lat = n;
    rdat = rsp_rdata;
    rerr = rsp_error;
    while (req_ready !== 1'b1) @(negedge clk);
  endtask : acc

  // ==========================================================================
  // Scenarios
  task automatic t_ext_read();
    dly <= 4'h1;
    acc(ebi_pkg::TGT_EXT, 1'b0, ebi_pkg::SZ_LONG, 32'h1234_5678, 32'h0);
    chk("rdata", dw(24'h34_5678), rdat);
    chk("error", 32'h0, {31'h0, rerr});
    chk("start", 32'h0, {31'h0, cbn[1]});
    chk("oe", 32'h0, {31'h0, coe[1]});
    chk("dir", 32'h1, {31'h0, crw[1]});
    chk("addr", 32'h0034_5678, cad[1]);
    chk("strobes", 32'h0, {28'h0, cbs[1]});
    chk("data_oe", 32'h0, cdoe[1]);
    chk("idle", 32'h1f, {27'h0, read_enable_n, byte_lane_strobe_n});
    chk("idle_data_oe", 32'h0, data_oe);
  endtask : t_ext_read

  task automatic t_ext_write();
    logic [1:0] sz[6] = '{0, 0, 0, 0, 1, 1};
    logic [1:0] ad[6] = '{0, 1, 2, 3, 0, 2};
    logic [3:0] ex[6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3};
    dly <= 4'h6;
    for (int i = 0; i < 6; i++)
    begin
      acc(ebi_pkg::TGT_EXT, 1'b1, sz[i], {30'h40, ad[i]}, 32'hc3a5_5a3c);
      chk("lane", {28'h0, ex[i]}, {28'h0, cbs[1]});
      chk("dir", 32'h0, {31'h0, crw[1]});
      chk("oe", 32'h1, {31'h0, coe[1]});
      chk("wdata", 32'hc3a5_5a3c, cdq[1]);
      chk("wdata_oe", 32'hffff_ffff, cdoe[1]);
    end
  endtask : t_ext_write

  task automatic t_error();
    err_mode <= 1'b1;
    acc(ebi_pkg::TGT_EXT, 1'b0, ebi_pkg::SZ_WORD, 32'h0000_0100, 32'h0);
    chk("error", 32'h1, {31'h0, rerr});
    err_mode <= 1'b0;
  endtask : t_error

  task automatic t_sdram();
    acc(ebi_pkg::TGT_SDRAM, 1'b0, ebi_pkg::SZ_LONG, 32'h00ab_cdef, 32'h0);
    chk("row", {17'h0, 15'h55e6}, cad[1]);
    chk("col", 32'h0000_01ef, cad[2]);
    chk("cas_row", 32'h0, {28'h0, cbs[1]});
    chk("cas_col", 32'hf, {28'h0, cbs[2]});
    chk("sd_rdata", dw(24'h00_55e6), rdat);
    acc(ebi_pkg::TGT_SDRAM, 1'b1, ebi_pkg::SZ_BYTE, 32'h0000_0201, 32'h00aa_0000);
    chk("cas_byte", 32'h2, {28'h0, cbs[2]});
    chk("sd_dir", 32'h0, {31'h0, crw[1]});
  endtask : t_sdram

  task automatic t_onchip();
    acc(ebi_pkg::TGT_CHIP_PER, 1'b0, ebi_pkg::SZ_BYTE, 32'h4000_0002, 32'h0);
    chk("per_lat", 32'h2, lat);
    chk("per_lane", 32'hb, {28'h0, cbs[1]});
    chk("per_start", 32'h1, {31'h0, cbn[1]});
    acc(ebi_pkg::TGT_CHIP_MEM, 1'b1, ebi_pkg::SZ_LONG, 32'h2000_0000, 32'h1);
    chk("mem_lat", 32'h1, lat);
    chk("mem_lane", 32'hf, {28'h0, cbs[1]});
  endtask : t_onchip

  task automatic t_config();
    @(posedge clk);
    cfg_cs_alt <= 1'b1;
    cfg_bus16 <= 1'b1;
    cfg_addr_gpio <= 24'h00_00f0;
    repeat (8) @(posedge clk);
    #1;
    chk("sel_oe", 32'h7, {29'h0, addr_oe[23:21]});
    chk("gpio_pins", 32'hf_a, {24'h0, addr_oe[7:4], addr_o[7:4]});
    chk("gpio_in", {8'h0, 3'h5, pad_lvl[20:8], 4'ha, pad_lvl[3:0]}, {8'h0, gpio_addr_in});
    chk("dgpio_oe", 32'h00ff, {16'h0, data_oe[15:0]});
    chk("dgpio_in", 32'h33, {24'h0, gpio_data_in[7:0]});
    acc(ebi_pkg::TGT_EXT, 1'b1, ebi_pkg::SZ_LONG, 32'h0000_0010, 32'h1111_2222);
    chk("bus16", 32'hc, {28'h0, cbs[1]});
    cfg_cs_alt <= 1'b0;
    cfg_bus16 <= 1'b0;
    cfg_addr_gpio <= 24'h0;
  endtask : t_config

  task automatic final_report();
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Clock, reset, sequence, watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {rstn, req_valid, req_write, cfg_bus16, cfg_cs_alt, err_mode} = 6'h0;
    {req_size, req_target, req_addr, req_wdata, dly} = '0;
    cs_alt_n = 3'h5;
    {cfg_addr_gpio, gpio_addr_out, gpio_addr_en} = {24'h0, 24'h0000a0, 24'h0000f0};
    pad_lvl = 24'h3c_5a96;
    gpio_data_out = 16'h0033;
    gpio_data_en = 16'h00ff;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_ext_read();
    t_ext_write();
    t_error();
    t_sdram();
    t_onchip();
    t_config();
    final_report();
  end

  initial
  begin
    #50000;
    errors++;
    final_report();
  end
endmodule : tb
